// >>> hdl/por_pkg.sv
// Purpose: Shared constants and types for the pulse output router.
// Assumes: One 40 MHz clock; flow and full scale are plain binary words.
// Notes:   Source codes follow the order of the routing selector.

package por_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_HZ            = 40_000_000;
  localparam int unsigned FREQ_LOW_HZ         = 1000;
  localparam int unsigned FREQ_HIGH_HZ        = 5000;
  localparam int unsigned QUARTERS_PER_PERIOD = 4;
  localparam int unsigned QUARTER_LOW_CYC     =
    CLOCK_HZ / (QUARTERS_PER_PERIOD * FREQ_LOW_HZ);
  localparam int unsigned QUARTER_HIGH_CYC    =
    CLOCK_HZ / (QUARTERS_PER_PERIOD * FREQ_HIGH_HZ);

  // ==========================================================
  // Widths
  localparam int FLOW_W   = 16;
  localparam int ACC_W    = 32;
  localparam int SRC_W    = 3;
  localparam int NUM_PINS = 6;
  localparam int NUM_SRC  = 8;
  localparam int NUM_LVL  = 4;
  localparam int FILL_W   = 3;

  // ==========================================================
  // Source select codes for every routed pin
  typedef enum logic [2:0] {
    POR_SRC_P1A = 3'h0,
    POR_SRC_L1A = 3'h1,
    POR_SRC_P1B = 3'h2,
    POR_SRC_L1B = 3'h3,
    POR_SRC_P2A = 3'h4,
    POR_SRC_L2A = 3'h5,
    POR_SRC_P2B = 3'h6,
    POR_SRC_L2B = 3'h7
  } por_src_e;

  // Direction modes of a pulse channel
  localparam logic [1:0] DIR_REVERSE  = 2'h0;
  localparam logic [1:0] DIR_FORWARD  = 2'h1;
  localparam logic [1:0] DIR_ABSOLUTE = 2'h2;
  localparam logic [1:0] DIR_BIDIR    = 2'h3;

  // Calibration run state, one-hot
  typedef enum logic [1:0] {
    POR_CAL_IDLE = 2'h1,
    POR_CAL_RUN  = 2'h2
  } por_cal_e;

endpackage

// >>> hdl/por_pulse_gen.sv
// Purpose: One quadrature pulse channel scaled from a flow word.
// Assumes: Flow is signed, positive meaning forward; full scale > 0.
// Notes:   Phase accumulator steps one quarter period per overflow.

`timescale 1ns/1ps

module por_pulse_gen
  import por_pkg::*;
#(
  parameter int W = FLOW_W
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic signed [W-1:0] flow_rate,
  input  wire logic        [W-1:0] full_scale,
  input  wire logic                max_freq_high,
  input  wire logic        [1:0]   dir_mode,
  input  wire logic                lead_forward,
  output logic                     phase_a,
  output logic                     phase_b
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [1:0]       cnt;
    logic             pa;
    logic             pb;
  } por_pg_s;

  por_pg_s          st_reg;
  por_pg_s          st_next;
  logic [W-1:0]     mag_abs;
  logic [W-1:0]     mag;
  logic             is_fwd;
  logic             is_rev;
  logic             fwd_sense;
  logic             count_up;
  logic             step;
  logic [ACC_W-1:0] limit;
  logic [ACC_W-1:0] sum;

  // ==========================================================
  // Rate scaling
  always_comb begin
    is_fwd  = !flow_rate[W-1] && (flow_rate != '0);
    is_rev  = flow_rate[W-1];
    mag_abs = is_rev ? W'(-flow_rate) : W'(flow_rate);
    mag     = '0;
    case (dir_mode)
      DIR_REVERSE: if (is_rev) mag = mag_abs;  // R9
      DIR_FORWARD: if (is_fwd) mag = mag_abs;  // R10
      default: mag = mag_abs;                  // R11
    endcase
    if (mag > full_scale) begin
      mag = full_scale;                        // R22
    end
    // Full scale lands on the chosen maximum frequency
    limit = ACC_W'(full_scale * (max_freq_high ? QUARTER_HIGH_CYC :
                                 QUARTER_LOW_CYC)); // R13 R21
    sum   = st_reg.acc + ACC_W'(mag);
    // A zero full scale clamps the flow to zero and clears the accumulator, so the channel stops
    step  = (full_scale != '0) && (mag != '0) && (sum >= limit); // R21 R22
    case (dir_mode)
      DIR_REVERSE: fwd_sense = 1'b0;
      DIR_FORWARD: fwd_sense = 1'b1;
      default:     fwd_sense = is_fwd;
    endcase
    // Counting up makes B lead A
    count_up = (dir_mode == DIR_BIDIR) ||
               (fwd_sense == lead_forward);    // R6 R7
    st_next = st_reg;
    if (full_scale == '0) begin
      st_next.acc = '0;
    end else if (step) begin
      st_next.acc = sum - limit;
    end else begin
      st_next.acc = sum;
    end
    if (step) begin
      st_next.cnt = count_up ? st_reg.cnt + 2'h1 : st_reg.cnt - 2'h1;
    end
    if (dir_mode == DIR_BIDIR) begin
      st_next.pa = is_fwd & st_next.cnt[1];    // R12
      st_next.pb = is_rev & st_next.cnt[1];    // R12
    end else begin
      st_next.pa = st_next.cnt[1];
      st_next.pb = ^st_next.cnt;               // R8
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase_a = st_reg.pa;
  assign phase_b = st_reg.pb;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_zero_flow_idle: assert property ((mag == '0) |=> $stable(st_reg.cnt))
    else $error("Quarter count moved with no flow"); // R22
  a_rate_saturate: assert property (mag <= full_scale)
    else $error("Scaled flow above full scale"); // R22
  a_bidir_a_only: assert property (
    (dir_mode == DIR_BIDIR && is_rev)[*2] |-> !phase_a)
    else $error("Reverse flow pulsed phase A"); // R12
  a_quarter_step: assert property (
    step |=> (st_reg.cnt == $past(st_reg.cnt) + 2'h1) ||
             (st_reg.cnt == $past(st_reg.cnt) - 2'h1))
    else $error("Quarter count skipped a step"); // R8
  a_fwd_only_idle: assert property (
    (dir_mode == DIR_FORWARD && !is_fwd) |-> !step)
    else $error("Forward-only channel stepped on reverse"); // R10

endmodule

// >>> hdl/por_level_out.sv
// Purpose: One level output carrying validity or direction.
// Assumes: Inputs come from logic on the same clock.
// Notes:   Inversion swaps the sense of the driven level.

`timescale 1ns/1ps

module por_level_out
  import por_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic func_direction,
  input  wire logic valid,
  input  wire logic flow_forward,
  input  wire logic invert,
  output logic      level
);

  typedef struct packed {
    logic lvl;
  } por_lvl_s;

  por_lvl_s st_reg;
  por_lvl_s st_next;
  logic     cond;

  always_comb begin
    cond        = func_direction ? flow_forward : valid;  // R5 R19
    st_next.lvl = cond ^ invert;                          // R20
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_level_sense: assert property (
    ##1 level == ($past(func_direction) ? $past(flow_forward) :
                  $past(valid)) ^ $past(invert))
    else $error("Level output sense wrong"); // R20

endmodule

// >>> hdl/por_output_router.sv
// Purpose: Routes pulse and level sources to six pins and decodes the
//          auxiliary input for calibration gating.
// Assumes: Pin six doubles as the auxiliary input; all configuration
//          inputs are steady, same-clock levels.
// Notes:   Summary of operation below.
//
// Summary of operation
// R1 - Each pin routes one of eight sources
// R2 - Pin six drives only when chosen as output
// R3 - Channel one sources carry its A/B phases
// R4 - Channel two sources carry its A/B phases
// R5 - Level outputs present validity or direction
// R6 - Lag-forward: B lags forward, leads reverse
// R7 - Lead-forward: B leads forward, lags reverse
// R8 - Quadrature modes offset B by quarter period
// R9 - Reverse-only mode pulses only on reverse
// R10 - Forward-only mode pulses only on forward
// R11 - Absolute mode pulses on flow magnitude
// R12 - Bidirectional: forward on A, reverse on B
// R13 - Maximum frequency selects 1000 or 5000 Hz
// R14 - Auxiliary polarity normal unless invert set
// R15 - Auxiliary input general purpose unless calibration
// R16 - Calibration active level low unless cleared
// R17 - Edge gating toggles run on each activation
// R18 - State gating runs while trigger stays active
// R19 - Level output function is validity or direction
// R20 - Inversion drives low for true condition
// R21 - Full scale flow maps to maximum frequency
// R22 - Saturate above full scale, silent at zero

`timescale 1ns/1ps

module por_output_router
  import por_pkg::*;
#(
  parameter int W = FLOW_W
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  // Pulse channel one
  input  wire logic signed [W-1:0] ch1_flow_rate,
  input  wire logic        [W-1:0] ch1_full_scale,
  input  wire logic                ch1_max_freq_high,
  input  wire logic        [1:0]   ch1_dir_mode,
  input  wire logic                ch1_lead_forward,
  input  wire logic                ch1_valid,
  // Pulse channel two
  input  wire logic signed [W-1:0] ch2_flow_rate,
  input  wire logic        [W-1:0] ch2_full_scale,
  input  wire logic                ch2_max_freq_high,
  input  wire logic        [1:0]   ch2_dir_mode,
  input  wire logic                ch2_lead_forward,
  input  wire logic                ch2_valid,
  // Level outputs, bit order ch1 A, ch1 B, ch2 A, ch2 B
  input  wire logic [NUM_LVL-1:0]  level_func_direction,
  input  wire logic [NUM_LVL-1:0]  level_invert,
  // Source selection per routed pin
  input  wire logic [SRC_W-1:0]    routed_pin_one_src,
  input  wire logic [SRC_W-1:0]    routed_pin_two_src,
  input  wire logic [SRC_W-1:0]    routed_pin_three_src,
  input  wire logic [SRC_W-1:0]    routed_pin_four_src,
  input  wire logic [SRC_W-1:0]    routed_pin_five_src,
  input  wire logic [SRC_W-1:0]    routed_pin_six_src,
  // Auxiliary input configuration
  input  wire logic                aux_pin_role_select,
  input  wire logic                aux_input_invert,
  input  wire logic                aux_for_calibration,
  input  wire logic                cal_trigger_active_low,
  input  wire logic                cal_trigger_level_gated,
  // Pins
  output logic                     routed_pin_one,
  output logic                     routed_pin_two,
  output logic                     routed_pin_three,
  output logic                     routed_pin_four,
  output logic                     routed_pin_five,
  input  wire logic                routed_pin_six_in,
  output logic                     routed_pin_six_out,
  output logic                     routed_pin_six_oe,
  // Auxiliary results
  output logic                     aux_input,
  output logic                     cal_running,
  output logic                     cal_start,
  output logic                     cal_stop
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                aux_meta;
    logic                aux_sync;
    logic                act_prev;
    logic [FILL_W-1:0]   fill;
    logic                aux_lvl;
    logic [NUM_PINS-2:0] pins;
    logic                pin6_out;
    logic                pin6_oe;
    por_cal_e            cal_state;
    logic                start_p;
    logic                stop_p;
  } por_rt_s;

  localparam por_rt_s RT_RESET = '{
    aux_meta:  1'b0,
    aux_sync:  1'b0,
    act_prev:  1'b0,
    fill:      '0,
    aux_lvl:   1'b0,
    pins:      '0,
    pin6_out:  1'b0,
    pin6_oe:   1'b0,
    cal_state: POR_CAL_IDLE,
    start_p:   1'b0,
    stop_p:    1'b0
  };

  por_rt_s              st_reg;
  por_rt_s              st_next;

  logic                 pulse_ch1_phase_a;
  logic                 pulse_ch1_phase_b;
  logic                 pulse_ch2_phase_a;
  logic                 pulse_ch2_phase_b;
  logic                 level_ch1_a;
  logic                 level_ch1_b;
  logic                 level_ch2_a;
  logic                 level_ch2_b;
  logic [NUM_SRC-1:0]   src_vec;
  logic [SRC_W-1:0]     sel [NUM_PINS];
  logic [NUM_LVL-1:0]   lvl_valid;
  logic [NUM_LVL-1:0]   lvl_fwd;
  logic [NUM_LVL-1:0]   lvl_out;
  logic                 ch1_fwd;
  logic                 ch2_fwd;
  logic                 aux_polar;
  logic                 cal_active;
  logic                 cal_en;
  logic                 cal_rise;
  logic                 cal_fall;
  logic                 primed;

  // ==========================================================
  // Pulse channels
  por_pulse_gen #(
    .W (W)
  ) u_pulse_ch1 (
    .clock         (clock),
    .reset_n       (reset_n),
    .flow_rate     (ch1_flow_rate),
    .full_scale    (ch1_full_scale),
    .max_freq_high (ch1_max_freq_high),
    .dir_mode      (ch1_dir_mode),
    .lead_forward  (ch1_lead_forward),
    .phase_a       (pulse_ch1_phase_a),    // R3
    .phase_b       (pulse_ch1_phase_b)     // R3
  );

  por_pulse_gen #(
    .W (W)
  ) u_pulse_ch2 (
    .clock         (clock),
    .reset_n       (reset_n),
    .flow_rate     (ch2_flow_rate),
    .full_scale    (ch2_full_scale),
    .max_freq_high (ch2_max_freq_high),
    .dir_mode      (ch2_dir_mode),
    .lead_forward  (ch2_lead_forward),
    .phase_a       (pulse_ch2_phase_a),    // R4
    .phase_b       (pulse_ch2_phase_b)     // R4
  );

  // ==========================================================
  // Level outputs
  assign ch1_fwd   = !ch1_flow_rate[W-1] && (ch1_flow_rate != '0);
  assign ch2_fwd   = !ch2_flow_rate[W-1] && (ch2_flow_rate != '0);
  assign lvl_valid = {ch2_valid, ch2_valid, ch1_valid, ch1_valid};
  assign lvl_fwd   = {ch2_fwd, ch2_fwd, ch1_fwd, ch1_fwd};

  for (genvar i = 0; i < NUM_LVL; i++) begin : g_level
    por_level_out u_level (
      .clock          (clock),
      .reset_n        (reset_n),
      .func_direction (level_func_direction[i]),  // R19
      .valid          (lvl_valid[i]),
      .flow_forward   (lvl_fwd[i]),
      .invert         (level_invert[i]),
      .level          (lvl_out[i])
    );
  end

  assign level_ch1_a = lvl_out[0];
  assign level_ch1_b = lvl_out[1];
  assign level_ch2_a = lvl_out[2];
  assign level_ch2_b = lvl_out[3];

  // ==========================================================
  // Routing matrix
  always_comb begin
    src_vec              = '0;
    src_vec[POR_SRC_P1A] = pulse_ch1_phase_a;
    src_vec[POR_SRC_L1A] = level_ch1_a;
    src_vec[POR_SRC_P1B] = pulse_ch1_phase_b;
    src_vec[POR_SRC_L1B] = level_ch1_b;
    src_vec[POR_SRC_P2A] = pulse_ch2_phase_a;
    src_vec[POR_SRC_L2A] = level_ch2_a;
    src_vec[POR_SRC_P2B] = pulse_ch2_phase_b;
    src_vec[POR_SRC_L2B] = level_ch2_b;
  end

  assign sel[0] = routed_pin_one_src;
  assign sel[1] = routed_pin_two_src;
  assign sel[2] = routed_pin_three_src;
  assign sel[3] = routed_pin_four_src;
  assign sel[4] = routed_pin_five_src;
  assign sel[5] = routed_pin_six_src;

  // ==========================================================
  // Auxiliary input decode
  always_comb begin
    // The first sync stage feeds nothing but the second
    aux_polar  = st_reg.aux_sync ^ aux_input_invert;       // R14
    cal_active = cal_trigger_active_low ? !aux_polar
                                        : aux_polar;       // R16
    // Pin six driven as an output cannot also be a trigger
    cal_en     = aux_for_calibration && !aux_pin_role_select; // R15
    // Ignore edges until the sync chain holds real pin samples
    primed     = st_reg.fill[FILL_W-1];
    cal_rise   = primed && cal_active && !st_reg.act_prev;
    cal_fall   = primed && !cal_active && st_reg.act_prev;
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next          = st_reg;
    st_next.aux_meta = routed_pin_six_in;
    st_next.aux_sync = st_reg.aux_meta;
    st_next.act_prev = cal_active;
    st_next.fill     = {st_reg.fill[FILL_W-2:0], 1'b1};
    st_next.start_p  = 1'b0;
    st_next.stop_p   = 1'b0;

    for (int i = 0; i < NUM_PINS - 1; i++) begin
      st_next.pins[i] = src_vec[sel[i]];                   // R1
    end
    st_next.pin6_out = aux_pin_role_select ?
                       src_vec[sel[NUM_PINS-1]] : 1'b0;    // R1
    st_next.pin6_oe  = aux_pin_role_select;                // R2

    // General-purpose level reads as zero while pin six drives
    st_next.aux_lvl  = !aux_pin_role_select && aux_polar;  // R14 R15

    case (st_reg.cal_state)
      POR_CAL_IDLE: begin
        if (cal_en && cal_rise) begin
          st_next.cal_state = POR_CAL_RUN;                 // R17 R18
          st_next.start_p   = 1'b1;
        end
      end
      POR_CAL_RUN: begin
        if (!cal_en) begin
          st_next.cal_state = POR_CAL_IDLE;                // R15
          st_next.stop_p    = 1'b1;
        end else if (cal_trigger_level_gated ? cal_fall
                                             : cal_rise) begin
          st_next.cal_state = POR_CAL_IDLE;                // R17 R18
          st_next.stop_p    = 1'b1;
        end
      end
      default: begin
        st_next.cal_state = POR_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= RT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign routed_pin_one     = st_reg.pins[0];
  assign routed_pin_two     = st_reg.pins[1];
  assign routed_pin_three   = st_reg.pins[2];
  assign routed_pin_four    = st_reg.pins[3];
  assign routed_pin_five    = st_reg.pins[4];
  assign routed_pin_six_out = st_reg.pin6_out;
  assign routed_pin_six_oe  = st_reg.pin6_oe;
  assign aux_input          = st_reg.aux_lvl;
  assign cal_running        = (st_reg.cal_state == POR_CAL_RUN);
  assign cal_start          = st_reg.start_p;
  assign cal_stop           = st_reg.stop_p;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_edge_arm;
    cal_en && !cal_trigger_level_gated && cal_rise;
  endsequence

  sequence s_state_release;
    cal_en && cal_trigger_level_gated && cal_fall && cal_running;
  endsequence

  sequence s_pin_steady;
    ($stable(routed_pin_six_in) && $stable(aux_input_invert) &&
     !aux_pin_role_select)[*4];
  endsequence

  a_pin_six_gate: assert property ( // R2
    !aux_pin_role_select |=> !routed_pin_six_oe && !routed_pin_six_out)
    else $error("Pin six driven while serving as input");

  a_route_select: assert property ( // R1
    ##1 routed_pin_one == $past(src_vec[routed_pin_one_src]))
    else $error("Pin one does not follow its source");

  a_route_six_out: assert property ( // R1
    aux_pin_role_select |=>
      routed_pin_six_out == $past(src_vec[routed_pin_six_src]))
    else $error("Pin six does not follow its source");

  a_cal_edge_toggle: assert property ( // R17
    s_edge_arm |=> (cal_running != $past(cal_running)) &&
                   (cal_start || cal_stop))
    else $error("Edge trigger did not toggle the run");

  a_cal_state_stop: assert property ( // R18
    s_state_release |=> !cal_running ##0 cal_stop)
    else $error("Level trigger release did not stop the run");

  a_cal_gp_idle: assert property ( // R15
    !aux_for_calibration |=> !cal_running)
    else $error("Run active in general-purpose use");

  a_aux_polarity: assert property ( // R14
    s_pin_steady |-> aux_input == (routed_pin_six_in ^ aux_input_invert))
    else $error("Auxiliary level has wrong polarity");

  a_cal_no_start: assert property ( // R16
    (!cal_running && !cal_rise) |=> !cal_start)
    else $error("Run started without a trigger activation");

endmodule

// >>> testbench/por_flow_computer.sv
// Purpose: Flow computer model that counts pulse pin rises.
// Assumes: Pins are sampled on the block clock.
// Notes:   Period is measured between the last two rises of pin A.
`timescale 1ns/1ps
module por_flow_computer (
  input  wire logic        clock,
  input  wire logic        clr,
  input  wire logic        pin_a,
  input  wire logic        pin_b,
  input  wire logic        pin_c,
  output logic [15:0]      rise_a,
  output logic [15:0]      rise_b,
  output logic [15:0]      rise_c,
  output logic             b_at_rise,
  output logic [31:0]      period
);
  logic [2:0]  prev = 3'h0;
  logic [31:0] cyc  = 32'h0;
  logic [31:0] last = 32'h0;
  // ==========================================================
  // Edge counting
  always @(posedge clock) begin
    prev <= {pin_c, pin_b, pin_a};
    cyc  <= cyc + 32'h1;
    if (clr) begin
      rise_a <= 16'h0;
      rise_b <= 16'h0;
      rise_c <= 16'h0;
    end else begin
      if (pin_a && !prev[0]) begin
        rise_a    <= rise_a + 16'h1;
        b_at_rise <= pin_b;
        period    <= cyc - last;
        last      <= cyc;
      end
      if (pin_b && !prev[1]) begin
        rise_b <= rise_b + 16'h1;
      end
      if (pin_c && !prev[2]) begin
        rise_c <= rise_c + 16'h1;
      end
    end
  end
endmodule

// >>> testbench/por_output_router_tb.sv
// Purpose: Self-checking bench for the pulse output router.
// Assumes: Inputs change on the falling edge only.
// Notes:   Small full scale keeps pulse periods short.
`timescale 1ns/1ps
module por_output_router_tb;
  import por_pkg::*;
  typedef struct {int sel; logic [31:0] val;} por_note_s;
  logic               clock = 1'b0, reset_n = 1'b0, clr = 1'b1;
  logic signed [15:0] ch1_flow_rate = '0, ch2_flow_rate = '0;
  logic [15:0]        ch1_full_scale = 16'h1, ch2_full_scale = 16'h1;
  logic               ch1_max_freq_high = 1'b1, ch2_max_freq_high = 1'b1;
  logic [1:0]         ch1_dir_mode = DIR_ABSOLUTE;
  logic [1:0]         ch2_dir_mode = DIR_ABSOLUTE;
  logic               ch1_lead_forward = 1'b1, ch2_lead_forward = 1'b1;
  logic               ch1_valid = 1'b0, ch2_valid = 1'b0;
  logic [3:0]         level_func_direction = '0, level_invert = '0, lv;
  logic [2:0]         src [6] = '{default: 3'h0};
  logic               aux_pin_role_select = 1'b0, aux_input_invert = 1'b0;
  logic               aux_for_calibration = 1'b0, routed_pin_six_in = 1'b1;
  logic               cal_trigger_active_low = 1'b1;
  logic               cal_trigger_level_gated = 1'b0;
  logic               routed_pin_one, routed_pin_two, routed_pin_three;
  logic               routed_pin_four, routed_pin_five, routed_pin_six_out;
  logic               routed_pin_six_oe, aux_input, cal_running;
  logic               cal_start, cal_stop, b_at_rise, e, role;
  logic [15:0]        rise_a, rise_b, rise_c;
  logic [31:0]        period, seed = 32'h43cf5059;
  int                 fails = 0, compares = 0;
  por_note_s          exp_q[$];
  event               chk_ev;
  initial begin
    forever #12.5 clock = ~clock;
  end
  por_output_router #(.W(16)) u_dut (
    .clock, .reset_n, .ch1_flow_rate, .ch1_full_scale, .ch1_max_freq_high,
    .ch1_dir_mode, .ch1_lead_forward, .ch1_valid, .ch2_flow_rate,
    .ch2_full_scale, .ch2_max_freq_high, .ch2_dir_mode, .ch2_lead_forward,
    .ch2_valid, .level_func_direction, .level_invert,
    .routed_pin_one_src(src[0]), .routed_pin_two_src(src[1]),
    .routed_pin_three_src(src[2]), .routed_pin_four_src(src[3]),
    .routed_pin_five_src(src[4]), .routed_pin_six_src(src[5]),
    .aux_pin_role_select, .aux_input_invert, .aux_for_calibration,
    .cal_trigger_active_low, .cal_trigger_level_gated, .routed_pin_one,
    .routed_pin_two, .routed_pin_three, .routed_pin_four, .routed_pin_five,
    .routed_pin_six_in, .routed_pin_six_out, .routed_pin_six_oe, .aux_input,
    .cal_running, .cal_start, .cal_stop);
  por_flow_computer u_fc (.clock, .clr, .pin_a(routed_pin_one),
    .pin_b(routed_pin_two), .pin_c(routed_pin_three), .rise_a, .rise_b,
    .rise_c, .b_at_rise, .period);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pick(input int sel);
    case (sel)
      0: return {25'h0, routed_pin_six_oe, routed_pin_six_out,
                 routed_pin_five, routed_pin_four, routed_pin_three,
                 routed_pin_two, routed_pin_one};
      1: return period;
      2: return {31'h0, b_at_rise};
      3: return {28'h0, cal_running, cal_start, cal_stop, aux_input};
      4: return {16'h0, rise_a};
      5: return {31'h0, |rise_b};
      default: return {16'h0, rise_c};
    endcase
  endfunction
  task automatic note(input int s, input logic [31:0] v);
    exp_q.push_back('{s, v});
    -> chk_ev;
  endtask
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cal_step(input logic v, input logic [3:0] x);
    routed_pin_six_in = v;
    repeat (3) @(negedge clock);
    note(3, {28'h0, x});
    @(negedge clock);
    // Start and stop are single-cycle pulses
    note(3, {28'h0, x[3], 2'b00, x[0]});
  endtask
  task automatic measure(input logic b);
    int n;
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    n = 0;
    // Third rise so the period is not skewed by a direction change
    while (rise_a < 16'h3 && n < 30000) begin
      @(negedge clock);
      n++;
    end
    if (n == 30000) begin
      fails++;
      finish_test();
    end
    note(1, CLOCK_HZ / FREQ_HIGH_HZ);
    note(2, {31'h0, b});
  endtask
  // ==========================================================
  // Checker process
  initial begin
    por_note_s nt;
    forever begin
      @(chk_ev);
      while (exp_q.size() > 0) begin
        nt = exp_q.pop_front();
        compares++;
        if (pick(nt.sel) !== nt.val) begin
          $display("unexpected at %0t got %h expected %h", $time,
                   pick(nt.sel), nt.val);
          fails++;
        end
      end
    end
  end
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    finish_test();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int r = 0; r < 2; r++) begin
      seed = lfsr(seed);
      {ch1_valid, ch2_valid, level_func_direction, level_invert} = seed[9:0];
      lv = (~level_func_direction & {ch2_valid, ch2_valid, ch1_valid,
           ch1_valid}) ^ level_invert;
      repeat (3) @(negedge clock);
      for (int c = 0; c < NUM_SRC; c++) begin
        src = '{default: c[2:0]};
        role = c[1];
        aux_pin_role_select = role;
        e = c[0] ? lv[c >> 1] : 1'b0;
        repeat (2) @(negedge clock);
        note(0, {25'h0, role, role & e, {5{e}}});
      end
    end
    $display("test routing done");
    src = '{3'h0, 3'h2, 3'h4, 3'h0, 3'h0, 3'h0};
    aux_pin_role_select = 1'b0;
    ch1_flow_rate = 16'sd100;
    measure(1'b1);
    ch1_lead_forward = 1'b0;
    measure(1'b0);
    ch1_dir_mode = DIR_REVERSE;
    ch1_flow_rate = -16'sd100;
    measure(1'b1);
    ch1_dir_mode = DIR_BIDIR;
    ch2_dir_mode = DIR_FORWARD;
    ch2_flow_rate = -16'sd100;
    repeat (2) @(negedge clock);
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    repeat (9000) @(negedge clock);
    note(4, 32'h0);
    note(5, 32'h1);
    note(6, 32'h0);
    ch2_dir_mode = DIR_ABSOLUTE;
    ch2_max_freq_high = 1'b0;
    ch2_flow_rate = 16'sd100;
    src[1] = 3'h6;
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    // Low range: B steps after 10000 cycles, A not before 20000
    repeat (12000) @(negedge clock);
    note(5, 32'h1);
    note(6, 32'h0);
    $display("test pulses done");
    aux_for_calibration = 1'b1;
    cal_step(1'b0, 4'b1100);
    cal_step(1'b1, 4'b1001);
    cal_step(1'b0, 4'b0010);
    cal_step(1'b1, 4'b0001);
    cal_trigger_level_gated = 1'b1;
    cal_step(1'b0, 4'b1100);
    cal_step(1'b1, 4'b0011);
    aux_input_invert = 1'b1;
    cal_trigger_active_low = 1'b0;
    cal_step(1'b0, 4'b1101);
    cal_step(1'b1, 4'b0010);
    aux_for_calibration = 1'b0;
    cal_step(1'b0, 4'b0001);
    cal_step(1'b1, 4'b0000);
    $display("test calibration done");
    @(negedge clock);
    finish_test();
  end
endmodule
